// ---- hw/acsp_port.sv ----
// serial command and result port of the differential converter
// How it works
// - result sent as two's complement with sign
// - sign zero when positive input not lower
// - codes span minus 4096 to plus 4095
// - chip select must be seen high first
// - first high data bit is start bit
// - leading zeros ignored before start bit
// - bit after start selects single or differential
// - single-ended result unipolar, sign always zero
// - three select bits follow, msb first
// - four-channel variant ignores top select bit
// - single-ended select bits are channel index
// - differential pairs, lowest bit swaps polarity
// - sampling starts fourth rising edge after start
// - sampling ends falling edge fifth clock
// - fifth clock data input is ignored
// - low null bit on sixth falling edge
// - sign then twelve bits, msb first
// - serial output changes only on falling edges or when chip select goes high
// - then result again, lsb first
// - then zeros while clocking continues
// - low power during result shifting
// - output high impedance before null bit
`default_nettype none
module acsp_port
  import acsp_pkg::*;
#(
  parameter bit EIGHT_CHAN = 1'b1
) (
  input  wire logic                   core_clk,
  input  wire logic                   arst_n,
  input  wire logic                   spiCsN,
  input  wire logic                   spiSclk,
  input  wire logic                   spiMosi,
  output logic                        spiMiso,
  output logic                        spiMisoOe,
  input  wire logic [ACSP_RES_W-1:0]  convCode,
  output logic                        sampleEn,
  output logic                        convStart,
  output logic                        lowPowerEn,
  output logic                        inputModeSelect,
  output logic      [ACSP_CHAN_W-1:0] posChan,
  output logic      [ACSP_CHAN_W-1:0] negChan,
  output logic                        negIsCommon,
  output logic                        busy
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge detection
  logic [ACSP_SYNC_W-1:0] pinSync;
  logic                   csNs;
  logic                   sclkS;
  logic                   mosiS;
  logic                   sclkPrev;
  logic                   sclkRise;
  logic                   sclkFall;
  logic                   csHigh;

  acsp_sync #(
    .WIDTH (ACSP_SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .asyncIn  ({spiCsN, spiSclk, spiMosi}),
    .resetVal (3'h0), // no false chip select high after reset, arming needs a real one
    .syncOut  (pinSync)
  );

  assign csNs  = pinSync[2];
  assign sclkS = pinSync[1];
  assign mosiS = pinSync[0];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkPrev <= 1'b0;
    end else begin
      sclkPrev <= sclkS;
    end
  end

  // edges counted only while selected
  assign sclkRise = sclkS & ~sclkPrev & ~csNs;
  assign sclkFall = ~sclkS & sclkPrev & ~csNs;
  assign csHigh   = csNs;

  ////////////////////////////////////////////////////////////////////////////
  // arming after power-up
  logic armed;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      armed <= 1'b0;
    end else if (csHigh) begin
      armed <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transaction state and clock counter
  acsp_state_t            state;
  logic [ACSP_CNT_W-1:0]  clkNum;
  logic                   chanSelBit2;
  logic                   chanSelBit1;
  logic                   chanSelBit0;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state  <= ACSP_ST_WAIT;
      clkNum <= '0;
    end else if (csHigh) begin
      state  <= ACSP_ST_WAIT;
      clkNum <= '0;
    end else begin
      unique case (state)
        ACSP_ST_WAIT: begin
          // zeros skipped, first high bit starts the command
          if (sclkRise && mosiS && armed) begin
            state  <= ACSP_ST_CMD;
            clkNum <= '0;
          end
        end
        ACSP_ST_CMD: begin
          if (sclkRise) begin
            clkNum <= clkNum + 6'h01;
          end else if (sclkFall && clkNum == ACSP_CLK_HOLD) begin
            state <= ACSP_ST_DATA;
          end
        end
        ACSP_ST_DATA: begin
          if (sclkRise && clkNum != ACSP_CLK_SAT) begin
            clkNum <= clkNum + 6'h01;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command bit capture
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      inputModeSelect <= ACSP_MODE_DIFF;
      chanSelBit2     <= 1'b0;
      chanSelBit1     <= 1'b0;
      chanSelBit0     <= 1'b0;
    end else if (state == ACSP_ST_CMD && sclkRise) begin
      // bit after start then select bits msb first
      unique case (clkNum + 6'h01)
        ACSP_CLK_MODE: inputModeSelect <= mosiS;
        ACSP_CLK_BIT2: chanSelBit2     <= mosiS;
        ACSP_CLK_BIT1: chanSelBit1     <= mosiS;
        ACSP_CLK_BIT0: chanSelBit0     <= mosiS;
        default: ; // fifth clock input ignored
      endcase
    end
  end

  acsp_chan_decode #(
    .EIGHT_CHAN (EIGHT_CHAN)
  ) u_decode (
    .inputModeSelect (inputModeSelect),
    .chanSelBit2     (chanSelBit2),
    .chanSelBit1     (chanSelBit1),
    .chanSelBit0     (chanSelBit0),
    .posChan         (posChan),
    .negChan         (negChan),
    .negIsCommon     (negIsCommon)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sample window and conversion start
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sampleEn  <= 1'b0;
      convStart <= 1'b0;
    end else begin
      convStart <= 1'b0;
      if (csHigh) begin
        sampleEn <= 1'b0;
      end else if (state == ACSP_ST_CMD && sclkRise && clkNum + 6'h01 == ACSP_CLK_BIT0) begin
        sampleEn <= 1'b1;
      end else if (state == ACSP_ST_CMD && sclkFall && clkNum == ACSP_CLK_HOLD) begin
        sampleEn  <= 1'b0;
        convStart <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result capture and serial output
  logic [ACSP_RES_W-1:0] result;
  logic                  nullSent;

  function automatic logic pick_bit(input logic [ACSP_CNT_W-1:0] n, input logic [ACSP_RES_W-1:0] r);
    logic [3:0] idx;
    idx = 4'h0;
    pick_bit = 1'b0;
    if (n >= ACSP_CLK_MSB0 && n <= ACSP_CLK_MSBN) begin
      idx = 4'(ACSP_CLK_MSBN - n);
      pick_bit = r[idx];
    end else if (n >= ACSP_CLK_LSB0 && n <= ACSP_CLK_LSBN) begin
      idx = 4'(n - ACSP_CLK_LSB0);
      pick_bit = r[idx];
    end
  endfunction

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      result <= ACSP_CODE_ZERO;
    end else if (state == ACSP_ST_DATA && sclkFall && clkNum == ACSP_CLK_NULL) begin
      // two's complement code, single-ended clamps to unipolar
      if (inputModeSelect == ACSP_MODE_SGL && convCode[ACSP_RES_W-1]) begin
        result <= ACSP_CODE_ZERO;
      end else begin
        result <= convCode;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      spiMiso   <= 1'b0;
      spiMisoOe <= 1'b0;
      nullSent  <= 1'b0;
    end else if (csHigh) begin
      spiMiso   <= 1'b0;
      spiMisoOe <= 1'b0;
      nullSent  <= 1'b0;
    end else if (state == ACSP_ST_DATA && sclkFall) begin
      // output moves only on falling edges
      if (clkNum == ACSP_CLK_NULL) begin
        spiMiso   <= 1'b0;
        spiMisoOe <= 1'b1;
        nullSent  <= 1'b1;
      end else if (nullSent) begin
        // msb first, then lsb first, then zeros
        spiMiso <= pick_bit(clkNum, result);
      end
    end
  end

  // bias and reference released while shifting
  assign lowPowerEn = nullSent;
  assign busy       = (state != ACSP_ST_WAIT);

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic fallAt;
  assign fallAt = (state == ACSP_ST_DATA) && sclkFall && !csHigh;

  sequence seq_sample_open;
    (state == ACSP_ST_CMD && sclkRise && !csHigh && clkNum == ACSP_CLK_HOLD - 6'h02) ##1 sampleEn;
  endsequence

  sequence seq_sample_close;
    (state == ACSP_ST_CMD && sclkFall && !csHigh && clkNum == ACSP_CLK_HOLD) ##1 (!sampleEn && convStart);
  endsequence

  sequence seq_mode_take;
    (state == ACSP_ST_CMD && sclkRise && clkNum + 6'h01 == ACSP_CLK_MODE)
      ##1 (inputModeSelect == $past(mosiS));
  endsequence

  sequence seq_hold_ignore;
    (state == ACSP_ST_CMD && sclkRise && clkNum + 6'h01 == ACSP_CLK_HOLD)
      ##1 $stable({inputModeSelect, chanSelBit2, chanSelBit1, chanSelBit0});
  endsequence

  AST_NOT_ARMED: assert property (!armed |-> state == ACSP_ST_WAIT)
    else $error("transaction started before chip select seen high");
  AST_START: assert property (state == ACSP_ST_WAIT && sclkRise && !mosiS |=> state == ACSP_ST_WAIT)
    else $error("zero bit taken as start");
  AST_SAMPLE_OPEN: assert property (state == ACSP_ST_CMD && sclkRise && !csHigh
                                    && clkNum == ACSP_CLK_HOLD - 6'h02 |-> seq_sample_open)
    else $error("sampling did not start on fourth rising edge");
  AST_SAMPLE_CLOSE: assert property (state == ACSP_ST_CMD && sclkFall && !csHigh
                                     && clkNum == ACSP_CLK_HOLD |-> seq_sample_close)
    else $error("sampling did not end on fifth falling edge");
  AST_NULL_BIT: assert property (fallAt && clkNum == ACSP_CLK_NULL |=> spiMisoOe && !spiMiso && lowPowerEn)
    else $error("null bit missing");
  AST_HIZ_BEFORE: assert property (!nullSent |-> !spiMisoOe)
    else $error("output driven before null bit");
  AST_MSB_SIGN: assert property (fallAt && clkNum == ACSP_CLK_MSB0 |=> spiMiso == result[ACSP_RES_W-1])
    else $error("sign bit not first");
  AST_MSB_LAST: assert property (fallAt && clkNum == ACSP_CLK_MSBN |=> spiMiso == result[0])
    else $error("lsb not last of msb-first word");
  AST_SGL_SIGN: assert property (fallAt && clkNum == ACSP_CLK_MSB0 && inputModeSelect |=> !spiMiso)
    else $error("single-ended sign not zero");
  AST_LSB_FIRST: assert property (fallAt && clkNum == ACSP_CLK_LSB0 + 6'h01 |=> spiMiso == result[1])
    else $error("lsb-first copy wrong");
  AST_ZEROS: assert property (fallAt && clkNum > ACSP_CLK_LSBN |=> !spiMiso)
    else $error("zeros not sent after copies");
  AST_FALL_ONLY: assert property ($changed(spiMiso) |-> $past(sclkFall) || $past(csHigh))
    else $error("output moved off a falling edge");
  AST_ABORT: assert property (csHigh |=> state == ACSP_ST_WAIT && !spiMisoOe && !sampleEn [*2])
    else $error("chip select high did not abort");

  ////////////////////////////////////////////////////////////////////////////
  // command capture and result path
  AST_START_TAKEN: assert property (state == ACSP_ST_WAIT && sclkRise && mosiS && armed
                                    |=> state == ACSP_ST_CMD && clkNum == 6'h00)
    else $error("start bit not taken");
  AST_MODE_TAKE: assert property (state == ACSP_ST_CMD && sclkRise
                                  && clkNum + 6'h01 == ACSP_CLK_MODE |-> seq_mode_take)
    else $error("mode bit not taken after start");
  AST_BIT2_TAKE: assert property (state == ACSP_ST_CMD && sclkRise
                                  && clkNum + 6'h01 == ACSP_CLK_BIT2 |=> chanSelBit2 == $past(mosiS))
    else $error("top select bit not taken");
  AST_BIT1_TAKE: assert property (state == ACSP_ST_CMD && sclkRise
                                  && clkNum + 6'h01 == ACSP_CLK_BIT1 |=> chanSelBit1 == $past(mosiS))
    else $error("middle select bit not taken");
  AST_BIT0_TAKE: assert property (state == ACSP_ST_CMD && sclkRise
                                  && clkNum + 6'h01 == ACSP_CLK_BIT0 |=> chanSelBit0 == $past(mosiS))
    else $error("lowest select bit not taken");
  AST_HOLD_IGNORED: assert property (state == ACSP_ST_CMD && sclkRise
                                     && clkNum + 6'h01 == ACSP_CLK_HOLD |-> seq_hold_ignore)
    else $error("data input used on hold clock");
  AST_CMD_STILL: assert property (state == ACSP_ST_CMD && !sclkRise && !csHigh |=> $stable(clkNum))
    else $error("clock count moved without a rising edge");
  AST_SAMPLE_IN_CMD: assert property (sampleEn |-> state == ACSP_ST_CMD)
    else $error("sample window open outside command phase");
  AST_CONV_ONE: assert property (convStart |=> !convStart)
    else $error("conversion start longer than one cycle");
  AST_DIFF_CODE: assert property (fallAt && clkNum == ACSP_CLK_NULL
                                  && inputModeSelect == ACSP_MODE_DIFF |=> result == $past(convCode))
    else $error("differential code not taken as is");
  AST_SGL_CLAMP: assert property (fallAt && clkNum == ACSP_CLK_NULL
                                  && inputModeSelect == ACSP_MODE_SGL |=> !result[ACSP_RES_W-1])
    else $error("single-ended result negative");
  AST_RESULT_HOLD: assert property (!(fallAt && clkNum == ACSP_CLK_NULL) |=> $stable(result))
    else $error("result moved outside null bit");
  AST_CNT_STEP: assert property (state == ACSP_ST_DATA && sclkRise
                                 && clkNum != ACSP_CLK_SAT |=> clkNum == $past(clkNum) + 6'h01)
    else $error("output clock count skipped");
  AST_LOW_POWER: assert property (lowPowerEn |-> state == ACSP_ST_DATA)
    else $error("low power outside result phase");
endmodule // acsp_port
`default_nettype wire

// ---- inc/acsp_pkg.sv ----
// constants and types shared by the serial command and result port
`default_nettype none
package acsp_pkg;
  localparam int unsigned ACSP_RES_W     = 13;
  localparam int unsigned ACSP_DATA_W    = 12;
  localparam int unsigned ACSP_CNT_W     = 6;
  localparam int unsigned ACSP_CHAN_W    = 3;
  localparam int unsigned ACSP_SYNC_W    = 3;
  // clock numbers counted from the start bit
  localparam logic [5:0] ACSP_CLK_MODE   = 6'h01;
  localparam logic [5:0] ACSP_CLK_BIT2   = 6'h02;
  localparam logic [5:0] ACSP_CLK_BIT1   = 6'h03;
  localparam logic [5:0] ACSP_CLK_BIT0   = 6'h04;
  localparam logic [5:0] ACSP_CLK_HOLD   = 6'h05;
  localparam logic [5:0] ACSP_CLK_NULL   = 6'h06;
  localparam logic [5:0] ACSP_CLK_MSB0   = 6'h07;
  localparam logic [5:0] ACSP_CLK_MSBN   = 6'h13;
  localparam logic [5:0] ACSP_CLK_LSB0   = 6'h14;
  localparam logic [5:0] ACSP_CLK_LSBN   = 6'h20;
  localparam logic [5:0] ACSP_CLK_SAT    = 6'h3f;
  localparam logic [12:0] ACSP_CODE_ZERO = 13'h0000;
  localparam logic [2:0] ACSP_CHAN_ZERO  = 3'h0;
  localparam logic       ACSP_MODE_SGL   = 1'b1;
  localparam logic       ACSP_MODE_DIFF  = 1'b0;
  typedef enum logic [2:0] {
    ACSP_ST_WAIT = 3'b001,
    ACSP_ST_CMD  = 3'b010,
    ACSP_ST_DATA = 3'b100
  } acsp_state_t;
endpackage
`default_nettype wire

// ---- hw/acsp_sync.sv ----
// two flip-flop synchroniser for pin inputs
`default_nettype none
module acsp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  input  wire logic [WIDTH-1:0] resetVal,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] preset;

  // reset value is a constant tie at the instance; applied after release
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      preset <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      preset <= '1;
      syncOut <= (preset == '1) ? stage1 : resetVal;
    end
  end
endmodule // acsp_sync
`default_nettype wire

// ---- hw/acsp_chan_decode.sv ----
// channel configuration decode for single-ended and differential modes
`default_nettype none
module acsp_chan_decode
  import acsp_pkg::*;
#(
  parameter bit EIGHT_CHAN = 1'b1
) (
  input  wire logic                   inputModeSelect,
  input  wire logic                   chanSelBit2,
  input  wire logic                   chanSelBit1,
  input  wire logic                   chanSelBit0,
  output logic      [ACSP_CHAN_W-1:0] posChan,
  output logic      [ACSP_CHAN_W-1:0] negChan,
  output logic                        negIsCommon
);
  logic topBit;

  always_comb begin
    // four-channel variant ignores the top select bit
    topBit = EIGHT_CHAN ? chanSelBit2 : 1'b0;
    if (inputModeSelect == ACSP_MODE_SGL) begin
      // binary channel index
      posChan     = {topBit, chanSelBit1, chanSelBit0};
      negChan     = ACSP_CHAN_ZERO;
      negIsCommon = 1'b1;
    end else begin
      // pair picked by upper bits, lowest bit swaps polarity
      posChan     = {topBit, chanSelBit1, chanSelBit0};
      negChan     = {topBit, chanSelBit1, ~chanSelBit0};
      negIsCommon = 1'b0;
    end
  end
endmodule // acsp_chan_decode
`default_nettype wire

// ---- testbench/acsp_host_model.sv ----
// host side model that drives the serial port pins
`default_nettype none
module acsp_host_model (
  input  wire logic core_clk,
  input  wire logic spiMiso,
  input  wire logic spiMisoOe,
  output logic      spiCsN,
  output logic      spiSclk,
  output logic      spiMosi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lastMiso;
  logic misoPin;
  logic idleHigh = 1'b0;
  initial begin
    spiCsN = 1'b0;  // pin already low at power-up
    spiSclk = 1'b0;
    spiMosi = 1'b0;
  end
  // released line shows the inverse of its last driven value
  always @(posedge core_clk) if (spiMisoOe) lastMiso <= spiMiso;
  assign misoPin = spiMisoOe ? spiMiso : ~lastMiso;
  //////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic deselect();
    spiCsN <= 1'b1;  // raising chip select ends the frame
    cyc(8);
  endtask
  // cmd is start, mode, then select bits; low phase 5 cycles, high phase 3
  task automatic frame(input int lead, input logic [4:0] cmd, input int nclk,
                       output logic [63:0] rx, output logic [63:0] rxOe);
    logic bitOut;
    rx = '0;
    rxOe = '0;
    spiSclk <= idleHigh;  // clock idles at either level, moved while deselected
    cyc(2);
    spiCsN <= 1'b0;  // frame opens with chip select low
    cyc(4);
    for (int i = -lead; i < nclk; i++) begin
      if (i < 0) bitOut = 1'b0;  // leading zeros
      else if (i < 5) bitOut = cmd[4 - i];  // start, mode then select bits msb first
      else if (i == 5) bitOut = 1'b1;  // don't-care clock driven high
      else bitOut = 1'b0;
      spiSclk <= 1'b0;
      spiMosi <= bitOut;
      cyc(5);
      spiSclk <= 1'b1;
      if (i >= 0) begin
        rx[i] = misoPin;  // latched at the rising edge
        rxOe[i] = spiMisoOe;
      end
      cyc(3);
    end
    spiSclk <= idleHigh;
    cyc(5);
  endtask
endmodule // acsp_host_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the serial command and result port
`default_nettype none
module tb_top
  import acsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, arst_n, spiCsN, spiSclk, spiMosi, spiMiso, spiMisoOe;
  logic sampleEn, convStart, lowPowerEn, inputModeSelect, negIsCommon, busy;
  logic [ACSP_RES_W-1:0]  convCode;
  logic [ACSP_CHAN_W-1:0] posChan, negChan;
  logic [63:0]            rx, rxOe;
  logic [ACSP_CHAN_W-1:0] posChan4, negChan4;
  logic                   negIsCommon4;
  int                     nConv = 0;
  int                     nSample = 0;
  int                     convMark = 0;
  int                     sampMark = 0;
  logic [12:0]            codes [8] = '{13'h1000, 13'h0fff, 13'h0000, 13'h1fff,
                                        13'h1a5c, 13'h0001, 13'h0555, 13'h1aaa};
  int                     failures = 0;
  int                     n_compared = 0;
  acsp_port #(.EIGHT_CHAN(1'b1)) dut_u (.core_clk(core_clk), .arst_n(arst_n), .spiCsN(spiCsN),
    .spiSclk(spiSclk), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .convCode(convCode),
    .sampleEn(sampleEn), .convStart(convStart), .lowPowerEn(lowPowerEn), .inputModeSelect(inputModeSelect),
    .posChan(posChan), .negChan(negChan), .negIsCommon(negIsCommon), .busy(busy));
  acsp_port #(.EIGHT_CHAN(1'b0)) dut4_u (.core_clk(core_clk), .arst_n(arst_n), .spiCsN(spiCsN),
    .spiSclk(spiSclk), .spiMosi(spiMosi), .spiMiso(), .spiMisoOe(), .convCode(convCode),
    .sampleEn(), .convStart(), .lowPowerEn(), .inputModeSelect(),
    .posChan(posChan4), .negChan(negChan4), .negIsCommon(negIsCommon4), .busy());
  always @(posedge convStart) nConv++;
  always @(posedge sampleEn) nSample++;
  acsp_host_model host_u (.core_clk(core_clk), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
    .spiCsN(spiCsN), .spiSclk(spiSclk), .spiMosi(spiMosi));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chkBit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chkVec(input string what, input logic [12:0] exp, input logic [12:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkFrame(input logic [12:0] exp);
    logic [12:0] msb, lsb;
    for (int k = 0; k < 13; k++) begin
      msb[12 - k] = rx[8 + k];
      lsb[k] = rx[21 + k];
    end
    chkBit("oe before null", 1'b0, rxOe[6]);
    chkBit("oe at null", 1'b1, rxOe[7]);
    chkBit("null bit", 1'b0, rx[7]);
    chkVec("msb first word", exp, msb);
    chkVec("lsb first word", exp, lsb);
    chkVec("trailing zeros", 13'h0000, {7'h00, rx[39:34]});
    chkBit("lowPowerEn", 1'b1, lowPowerEn);
    chkBit("sample window once", 1'b1, nSample == sampMark + 1);
    chkBit("convStart once", 1'b1, nConv == convMark + 1);
  endtask
  task automatic chkChan(input logic [2:0] p, input logic [2:0] n, input logic c);
    chkVec("posChan", {10'h000, p}, {10'h000, posChan});
    chkVec("negChan", {10'h000, n}, {10'h000, negChan});
    chkBit("negIsCommon", c, negIsCommon);
    chkVec("posChan four", {10'h000, p & 3'h3}, {10'h000, posChan4});
    chkVec("negChan four", {10'h000, n & 3'h3}, {10'h000, negChan4});
    chkBit("negIsCommon four", c, negIsCommon4);
  endtask
  task automatic chkIdle();
    chkBit("oe idle", 1'b0, spiMisoOe);
    chkBit("busy idle", 1'b0, busy);
    chkBit("sampleEn idle", 1'b0, sampleEn);
    chkBit("lowPowerEn idle", 1'b0, lowPowerEn);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_arm();
    host_u.frame(0, 5'b11000, 3, rx, rxOe);
    chkBit("busy unarmed", 1'b0, busy);
    host_u.deselect();
  endtask
  task automatic t_diff();
    for (int c = 0; c < 8; c++) begin
      @(posedge core_clk);
      convCode <= codes[c];
      convMark = nConv;
      sampMark = nSample;
      host_u.frame(c, {2'b10, 3'(c)}, 40, rx, rxOe);
      chkFrame(codes[c]);
      chkBit("mode diff", ACSP_MODE_DIFF, inputModeSelect);
      chkChan(3'(c), 3'(c) ^ 3'h1, 1'b0);
      host_u.deselect();
      chkIdle();
    end
  endtask
  task automatic t_abort();
    host_u.frame(0, 5'b11000, 11, rx, rxOe);
    chkBit("busy mid frame", 1'b1, busy);
    host_u.deselect();
    chkIdle();
  endtask
  task automatic t_single();
    for (int c = 0; c < 8; c++) begin
      @(posedge core_clk);
      convCode <= codes[c];
      convMark = nConv;
      sampMark = nSample;
      host_u.idleHigh = c[0];  // odd frames with the clock idling high
      host_u.frame(7 - c, {2'b11, 3'(c)}, 40, rx, rxOe);
      chkFrame(codes[c][12] ? 13'h0000 : codes[c]);
      chkBit("mode single", ACSP_MODE_SGL, inputModeSelect);
      chkChan(3'(c), 3'h0, 1'b1);
      host_u.deselect();
    end
  endtask
  initial begin
    arst_n = 1'b0;
    convCode = 13'h0000;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_arm();
    t_diff();
    t_abort();
    t_single();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
